/* hw/dac_serial_pkg.sv */
package dac_serial_pkg;

    // frame geometry
    localparam int FRAME_BITS = 16;
    localparam int ABORT_BEFORE_EDGE = 15;
    localparam int CHAIN_AFTER_EDGES = 16;
    localparam int EDGE_CNT_W = 5;
    localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_MAX = 5'h11;
    localparam logic [EDGE_CNT_W-1:0] EDGE_LAST = 5'h0F;
    localparam logic [EDGE_CNT_W-1:0] EDGE_CHAIN = 5'h10;

    // channel array
    localparam int CHANNELS = 8;
    localparam int CODE_W = 12;

    // command word layout
    localparam int CMD_KIND_BIT = 15;
    localparam int CMD_OP_HI = 14;
    localparam int CMD_OP_LO = 12;
    localparam int CMD_DATA_HI = 11;
    localparam int CMD_MASK_HI = 7;
    localparam int CMD_MODE_BIT = 0;

    // special command opcodes, used when the kind bit is set
    localparam logic [2:0] OP_SET_MODE = 3'h0;
    localparam logic [2:0] OP_UPDATE = 3'h1;
    localparam logic [2:0] OP_POWER_DOWN = 3'h2;
    localparam logic [2:0] OP_POWER_UP = 3'h3;

    // reset values
    localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
    localparam logic [CHANNELS-1:0] MASK_RESET = 8'h00;
    localparam logic MODE_RESET = 1'b0;

endpackage : dac_serial_pkg

/* hw/bit_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser; first stage feeds only the second
module bit_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic d,
    output logic q
);

    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // next values
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // register stages
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            q <= q_nxt;
        end
    end

endmodule : bit_sync

`default_nettype wire

/* hw/channel_slot.sv */
`timescale 1ns/1ns
`default_nettype none

// one channel: input register plus output code
module channel_slot
    import dac_serial_pkg::*;
#(
    parameter int WIDTH = CODE_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic update_en,
    output logic [WIDTH-1:0] hold_value,
    output logic [WIDTH-1:0] out_value
);

    logic [WIDTH-1:0] hold_nxt;
    logic [WIDTH-1:0] out_nxt;

    // a write and update in the same cycle passes the new code straight on
    always_comb begin
        hold_nxt = wr_en ? data_in : hold_value;
        out_nxt = update_en ? hold_nxt : out_value;
    end

    // output stays at zero until the first update arrives
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_value <= WIDTH'(CODE_RESET);
            out_value <= WIDTH'(CODE_RESET);
        end else begin
            hold_value <= hold_nxt;
            out_value <= out_nxt;
        end
    end

endmodule : channel_slot

`default_nettype wire

/* hw/dac_serial_frame_input.sv */
// What this block does
// - while frame select is low, data is captured on each falling shift-clock edge
// - input word is sixteen bits, sampled on falling edges after frame select falls
// - frame select rising after the sixteenth edge applies the captured word
// - frame select rising before the fifteenth edge aborts; nothing changes
// - chain output carries shifted data only after frame select stays low past 16 clocks
// - the word selects mode, power-down state and channel register or output codes
// - channel outputs stay zero after reset until the first complete valid frame
`timescale 1ns/1ns
`default_nettype none

module dac_serial_frame_input
    import dac_serial_pkg::*;
#(
    parameter int NUM_CH = CHANNELS,
    parameter int CODE_BITS = CODE_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic serial_shift_clock,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    output logic chain_data_out,
    output logic [NUM_CH*CODE_BITS-1:0] channel_code,
    output logic [NUM_CH-1:0] power_down,
    output logic write_through,
    output logic outputs_enabled,
    output logic [FRAME_BITS-1:0] last_word,
    output logic word_strobe,
    output logic abort_strobe
);

    // ------------------------------------------------------------------
    // link domain: runs only on falling shift-clock edges
    // the controller may stop this clock between frames or keep it running
    // for other parts on a shared line, so frame select gates every change
    // and no state here relies on edges after the frame ends
    // ------------------------------------------------------------------

    // the edge counter ends with the frame itself, since the shift
    // clock may stop as soon as frame select goes high,
    // so every frame starts counting from zero
    logic link_rst_n;
    assign link_rst_n = arst_n & ~frame_select_n;

    // counter, chain bit, shifter and completion toggle
    logic [EDGE_CNT_W-1:0] edge_cnt_r;
    logic [EDGE_CNT_W-1:0] edge_cnt_nxt;
    logic chain_r;
    logic chain_nxt;
    logic [FRAME_BITS-1:0] shift_r;
    logic [FRAME_BITS-1:0] shift_nxt;
    logic done_tgl_r;
    logic done_tgl_nxt;

    // edge count saturates so long daisy-chain frames never wrap
    always_comb begin
        if (edge_cnt_r == EDGE_CNT_MAX) begin
            edge_cnt_nxt = edge_cnt_r;
        end else begin
            edge_cnt_nxt = edge_cnt_r + 5'h01;
        end
        // the bit leaving the top only goes out past sixteen clocks
        if (edge_cnt_r >= EDGE_CHAIN) begin
            chain_nxt = shift_r[FRAME_BITS-1];
        end else begin
            chain_nxt = 1'b0;
        end
    end

    // counter and chain output clear while frame select is high
    always_ff @(negedge serial_shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            edge_cnt_r <= '0;
            chain_r <= 1'b0;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
            chain_r <= chain_nxt;
        end
    end

    assign chain_data_out = chain_r;

    // shifter ignores edges meant for other devices on a shared clock
    always_comb begin
        if (!frame_select_n) begin
            shift_nxt = {shift_r[FRAME_BITS-2:0], serial_data_in};
        end else begin
            shift_nxt = shift_r;
        end
        // completion is signalled by a toggle so the clk side sees an event
        if (!frame_select_n && edge_cnt_r == EDGE_LAST) begin
            done_tgl_nxt = ~done_tgl_r;
        end else begin
            done_tgl_nxt = done_tgl_r;
        end
    end

    // word and toggle survive the end of a frame for the clk side to read
    always_ff @(negedge serial_shift_clock or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= WORD_RESET;
            done_tgl_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            done_tgl_r <= done_tgl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // crossing into the clk domain
    // only two single bits cross: the frame select level and a
    // completion toggle; the shifted word is read only after the synced
    // rise, when the shift clock no longer moves it
    // ------------------------------------------------------------------

    // clk-side copies of the two crossing bits
    logic frame_n_s;
    logic done_tgl_s;

    bit_sync #(
        .RESET_VAL(1'b1)
    ) u_frame_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(frame_select_n),
        .q(frame_n_s)
    );

    bit_sync #(
        .RESET_VAL(1'b0)
    ) u_done_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(done_tgl_r),
        .q(done_tgl_s)
    );

    // ------------------------------------------------------------------
    // frame end: commit or abort
    // verdict timing: two sync edges, combinational rise detect, registered strobe;
    // a rise between the fifteenth and sixteenth edges finds no toggle
    // and is refused like any other short frame
    // ------------------------------------------------------------------

    // frame phase as seen through the synchroniser; idle matches the
    // reset level of the synced pin, so no false rise follows reset
    typedef enum logic {
        FRAME_IDLE = 1'b0,
        FRAME_OPEN = 1'b1
    } frame_phase_e;

    // frame-end state and its next values
    frame_phase_e phase_r;
    frame_phase_e phase_nxt;
    logic done_seen_r;
    logic done_seen_nxt;
    logic frame_rise;
    logic done_fresh;
    logic commit;
    logic abort;
    logic [FRAME_BITS-1:0] word_nxt;
    logic word_strobe_nxt;
    logic abort_strobe_nxt;
    logic enabled_nxt;

    // the shift register is static once frame select is high, so it is
    // sampled here as a quasi-static word qualified by the synced edge
    always_comb begin
        phase_nxt = phase_r;
        frame_rise = 1'b0;
        unique case (phase_r)
            FRAME_IDLE: begin
                phase_nxt = frame_n_s ? FRAME_IDLE : FRAME_OPEN;
            end
            FRAME_OPEN: begin
                phase_nxt = frame_n_s ? FRAME_IDLE : FRAME_OPEN;
                frame_rise = frame_n_s;
            end
        endcase
        // an early rise finds no new completion toggle
        done_fresh = done_tgl_s != done_seen_r;
        commit = frame_rise && done_fresh;
        abort = frame_rise && !done_fresh;
        done_seen_nxt = frame_rise ? done_tgl_s : done_seen_r;
        word_nxt = commit ? shift_r : last_word;
        word_strobe_nxt = commit;
        abort_strobe_nxt = abort;
        enabled_nxt = outputs_enabled | commit;
    end

    // frame tracking and result flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= FRAME_IDLE;
            done_seen_r <= 1'b0;
            last_word <= WORD_RESET;
            word_strobe <= 1'b0;
            abort_strobe <= 1'b0;
            outputs_enabled <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            done_seen_r <= done_seen_nxt;
            last_word <= word_nxt;
            word_strobe <= word_strobe_nxt;
            abort_strobe <= abort_strobe_nxt;
            outputs_enabled <= enabled_nxt;
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // kind bit low writes one channel, whose output also moves in
    // write-through mode; kind bit high carries a special command
    // ------------------------------------------------------------------

    // decode results for this cycle
    logic [NUM_CH-1:0] ch_wr;
    logic [NUM_CH-1:0] ch_upd;
    logic [NUM_CH-1:0] pd_nxt;
    logic mode_nxt;
    logic [2:0] op;
    logic [NUM_CH-1:0] mask;
    logic [CODE_BITS-1:0] wr_code;

    // kind bit low: channel write; high: mode, update or power command
    always_comb begin
        ch_wr = '0;
        ch_upd = '0;
        pd_nxt = power_down;
        mode_nxt = write_through;
        op = shift_r[CMD_OP_HI:CMD_OP_LO];
        mask = shift_r[CMD_MASK_HI:0];
        wr_code = shift_r[CODE_BITS-1:0];
        if (commit) begin
            if (!shift_r[CMD_KIND_BIT]) begin
                ch_wr[op] = 1'b1;
                ch_upd[op] = write_through;
            end else begin
                unique case (op)
                    OP_SET_MODE: begin
                        mode_nxt = shift_r[CMD_MODE_BIT];
                    end
                    OP_UPDATE: begin
                        // held codes move to the outputs together
                        ch_upd = mask;
                    end
                    OP_POWER_DOWN: begin
                        pd_nxt = power_down | mask;
                    end
                    OP_POWER_UP: begin
                        pd_nxt = power_down & ~mask;
                    end
                    3'h4, 3'h5, 3'h6, 3'h7: begin
                        // reserved opcodes are accepted and do nothing
                        pd_nxt = power_down;
                    end
                endcase
            end
        end
    end

    // mode and power-down state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_down <= MASK_RESET;
            write_through <= MODE_RESET;
        end else begin
            power_down <= pd_nxt;
            write_through <= mode_nxt;
        end
    end

    // ------------------------------------------------------------------
    // channel registers and output codes
    // each slot holds a written code and copies it out on update, so
    // several channels can change output on the same clock edge,
    // and a power-down flag leaves the held code untouched
    // ------------------------------------------------------------------

    // outputs reset to zero and move only on a committed frame
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            channel_slot #(
                .WIDTH(CODE_BITS)
            ) u_slot (
                .clk(clk),
                .arst_n(arst_n),
                .wr_en(ch_wr[g]),
                .data_in(wr_code),
                .update_en(ch_upd[g]),
                .hold_value(),
                .out_value(channel_code[g*CODE_BITS +: CODE_BITS])
            );
        end
    endgenerate

endmodule : dac_serial_frame_input

`default_nettype wire

/* verif/dac_serial_frame_input_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// watches the frame port from the system clock side
module dac_serial_frame_input_properties
    import dac_serial_pkg::*;
#(
    parameter int NUM_CH = CHANNELS,
    parameter int CODE_BITS = CODE_W
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic frame_select_n,
    input wire logic chain_data_out,
    input wire logic [NUM_CH*CODE_BITS-1:0] channel_code,
    input wire logic [NUM_CH-1:0] power_down,
    input wire logic outputs_enabled,
    input wire logic [FRAME_BITS-1:0] last_word,
    input wire logic word_strobe,
    input wire logic abort_strobe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // verdicts are single pulses
    AST_WORD_PULSE: assert property (word_strobe |=> !word_strobe)
        else $error("word strobe too long");
    AST_ABORT_PULSE: assert property (abort_strobe |=> !abort_strobe)
        else $error("abort strobe too long");
    // a closed frame gets its verdict after the synchroniser delay
    AST_RISE_ANSWER: assert property ($rose(frame_select_n)
        |-> ##[1:5] (word_strobe || abort_strobe)) else $error("no verdict");
    AST_VERDICT_IDLE: assert property ((word_strobe || abort_strobe)
        |-> frame_select_n && $past(frame_select_n, 2)) else $error("verdict mid frame");
    // outputs move only with a committed word
    AST_HOLD: assert property ((!$stable(channel_code) || !$stable(power_down)
        || !$stable(last_word)) |-> word_strobe) else $error("outputs moved");
    AST_ZERO_FIRST: assert property (!outputs_enabled |-> channel_code == '0)
        else $error("code before first frame");
    AST_ENABLE_STICKY: assert property (outputs_enabled |=> outputs_enabled)
        else $error("enable dropped");
    // chain stays quiet outside frames so a chained part sees no junk
    AST_CHAIN_QUIET: assert property (frame_select_n |-> !chain_data_out)
        else $error("chain active outside frame");
endmodule : dac_serial_frame_input_properties
`default_nettype wire

/* verif/serial_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host side of the link; shift clock stands high between frames
module serial_host_model (
    output logic serial_shift_clock,
    output logic frame_select_n,
    output logic serial_data_in,
    input wire logic chain_data_out
);
    logic [31:0] chain_seen;
    initial begin
        serial_shift_clock = 1'b1;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
        chain_seen = '0;
    end
    // n bits msb first at a 160 ns period; odd start offset keeps phase unrelated
    task automatic send(input logic [31:0] bits, input int n);
        #7;
        frame_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in = bits[i];
            #40 serial_shift_clock = 1'b0;
            #80 serial_shift_clock = 1'b1;
            chain_seen[n-1-i] = chain_data_out;
            #40;
        end
        frame_select_n = 1'b1;
        serial_data_in = ~serial_data_in; // released line shows no stale bit
    endtask : send
endmodule : serial_host_model
`default_nettype wire

/* verif/dac_serial_frame_input_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_serial_frame_input_tb;
    import dac_serial_pkg::*;
    logic clk;
    logic arst_n;
    wire logic serial_shift_clock, frame_select_n, serial_data_in, chain_data_out;
    logic [CHANNELS*CODE_W-1:0] channel_code;
    logic [CHANNELS-1:0] power_down;
    logic write_through, outputs_enabled, word_strobe, abort_strobe;
    logic [FRAME_BITS-1:0] last_word;
    logic [1:0] v;
    int mismatches = 0;
    int total_checks = 0;

    dac_serial_frame_input u_dac_serial_frame_input (
        .clk(clk), .arst_n(arst_n), .serial_shift_clock(serial_shift_clock),
        .frame_select_n(frame_select_n), .serial_data_in(serial_data_in),
        .chain_data_out(chain_data_out), .channel_code(channel_code),
        .power_down(power_down), .write_through(write_through),
        .outputs_enabled(outputs_enabled), .last_word(last_word),
        .word_strobe(word_strobe), .abort_strobe(abort_strobe));
    serial_host_model u_serial_host_model (
        .serial_shift_clock(serial_shift_clock), .frame_select_n(frame_select_n),
        .serial_data_in(serial_data_in), .chain_data_out(chain_data_out));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // four-state compare so an unknown never matches
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    function automatic logic [CODE_W-1:0] code_of(input int g);
        return channel_code[g*CODE_W +: CODE_W];
    endfunction : code_of
    // one frame, then eight clocks to collect the verdict; also covers the gap
    task automatic send_frame(input logic [31:0] bits, input int n);
        v = 2'b00;
        u_serial_host_model.send(bits, n);
        repeat (8) begin
            @(posedge clk);
            #1 v = v | {word_strobe, abort_strobe};
        end
    endtask : send_frame
    task automatic t_reset();
        @(negedge clk);
        arst_n = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({outputs_enabled, write_through, power_down, last_word}, '0);
        chk(channel_code, '0);
    endtask : t_reset
    // short frames, the last ending just before edge 15
    task automatic t_abort();
        send_frame(16'h3ABC, 1);
        chk(v, 2'b01);
        send_frame(16'h3ABC, 14);
        chk(v, 2'b01);
        chk({outputs_enabled, last_word}, '0);
        chk(channel_code, '0);
    endtask : t_abort
    task automatic t_write();
        send_frame(16'h3ABC, 16);
        chk(v, 2'b10);
        chk(last_word, 16'h3ABC);
        chk(outputs_enabled, 1'b1);
        chk(code_of(3), '0);
        send_frame(16'h9008, 16);
        chk(code_of(3), 12'hABC);
    endtask : t_write
    task automatic t_mode();
        send_frame(16'h8001, 16);
        chk(write_through, 1'b1);
        send_frame(16'h5123, 16);
        chk(code_of(5), 12'h123);
        send_frame(16'h8000, 16);
        chk(write_through, 1'b0);
    endtask : t_mode
    // set, clear, then the unused opcodes must leave power state alone
    task automatic t_power();
        send_frame(16'hA0F0, 16);
        chk(power_down, 8'hF0);
        send_frame(16'hB030, 16);
        chk(power_down, 8'hC0);
        for (int op = 4; op < 8; op++) begin
            send_frame({1'b1, op[2:0], 12'h0FF}, 16);
            chk({power_down, last_word}, {8'hC0, 1'b1, op[2:0], 12'h0FF});
        end
    endtask : t_power
    // 20-bit frame: last 16 bits commit, first 4 leave on the chain
    task automatic t_chain();
        logic [19:0] b;
        b = 20'hB_2DA5;
        send_frame(b, 20);
        chk({v, last_word}, {2'b10, 16'h2DA5});
        chk(code_of(2), '0);
        for (int k = 1; k <= 20; k++) begin
            chk(u_serial_host_model.chain_seen[k-1], k > 16 ? b[36-k] : 1'b0);
        end
    endtask : t_chain
    // done toggle and its clk-side copy both restart from zero
    task automatic t_after_reset();
        send_frame(16'h1456, 16);
        chk(v, 2'b10);
        chk({outputs_enabled, last_word}, {1'b1, 16'h1456});
        chk(code_of(1), '0);
    endtask : t_after_reset
    initial begin
        arst_n = 1'b0;
        t_reset();
        t_abort();
        t_write();
        t_mode();
        t_power();
        t_chain();
        t_reset();
        t_after_reset();
        report_and_stop();
    end
    // about seven and a half times the expected run
    initial begin
        #300000;
        mismatches++;
        report_and_stop();
    end
endmodule : dac_serial_frame_input_tb

bind dac_serial_frame_input dac_serial_frame_input_properties #(
    .NUM_CH(NUM_CH), .CODE_BITS(CODE_BITS)) u_props (
    .clk(clk), .arst_n(arst_n), .frame_select_n(frame_select_n),
    .chain_data_out(chain_data_out), .channel_code(channel_code),
    .power_down(power_down), .outputs_enabled(outputs_enabled),
    .last_word(last_word), .word_strobe(word_strobe), .abort_strobe(abort_strobe));
`default_nettype wire
